// ===== lcd_feed_pkg.sv
// constants for the dual-half lcd line feed
package lcd_feed_pkg;
	localparam int ROW_DOTS       = 640;
	localparam int ROWS_PER_HALF  = 100;
	localparam int NIBBLE_W       = 4;
	localparam int CLKS_PER_DRV   = 20;
	localparam int NUM_DRIVERS    = ROW_DOTS / (NIBBLE_W * CLKS_PER_DRV);
	localparam int CLKS_PER_ROW   = ROW_DOTS / NIBBLE_W;
	localparam int ROW_IDX_W      = 7;
	localparam int DRV_IDX_W      = 3;
	localparam int NIB_IDX_W      = 8;
	localparam int DRV_CNT_W      = 5;
	localparam logic [ROW_IDX_W-1:0] ROW_LAST = 7'h63;
	localparam logic [DRV_CNT_W-1:0] DRV_CNT_LAST = 5'h13;
endpackage : lcd_feed_pkg

// ===== lcd_column_half.sv
// one panel half: column shift buffer, row latch and column polarity
`timescale 1ns/10ps
`default_nettype none
module lcd_column_half
	import lcd_feed_pkg::*;
(
	// clock and reset
	input  wire logic                          mclk_in,
	input  wire logic                          sys_rst_in,
	// shift and latch control
	input  wire logic                          shift_in,
	input  wire logic [lcd_feed_pkg::DRV_IDX_W-1:0] drv_sel_in,
	input  wire logic [lcd_feed_pkg::DRV_CNT_W-1:0] drv_pos_in,
	input  wire logic                          latch_in,
	input  wire logic                          polarity_in,
	input  wire logic [lcd_feed_pkg::NIBBLE_W-1:0]  nibble_in,
	// column drive
	output logic      [lcd_feed_pkg::ROW_DOTS-1:0]  column_out
);
	import lcd_feed_pkg::*;

	logic [NIBBLE_W-1:0] shift_reg [NUM_DRIVERS][CLKS_PER_DRV];
	logic [ROW_DOTS-1:0] latch_reg;

	// ==========================================
	// driver data inputs
	// only the selected driver takes the bus; others hold still to save power
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int d = 0; d < NUM_DRIVERS; d++) begin
				for (int c = 0; c < CLKS_PER_DRV; c++) begin
					shift_reg[d][c] <= 4'h0;
				end
			end
		end else if (shift_in) begin
			shift_reg[drv_sel_in][drv_pos_in] <= nibble_in; // RULE12
		end
	end

	// ==========================================
	// row latch, dot 0 is leftmost, nibble bit 3 first
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			latch_reg <= '0;
		end else if (latch_in) begin
			for (int d = 0; d < NUM_DRIVERS; d++) begin
				for (int c = 0; c < CLKS_PER_DRV; c++) begin
					for (int b = 0; b < NIBBLE_W; b++) begin
						latch_reg[(d * CLKS_PER_DRV + c) * NIBBLE_W + b] <=
							shift_reg[d][c][NIBBLE_W-1-b]; // RULE3
					end
				end
			end
		end
	end

	// ==========================================
	// column drive, inverted in the reversed phase
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			column_out <= '0;
		end else begin
			column_out <= polarity_in ? ~latch_reg : latch_reg; // RULE8
		end
	end
endmodule : lcd_column_half
`default_nettype wire

// ===== dual_half_lcd_line_feed.sv
// panel-side line feed: sampling, driver select, row scan, polarity
// What this block does
// RULE1 - the panel is two halves of 640x100 dots, each scanned one row in 100.
// RULE2 - each half takes one 4-bit nibble per shift clock from the top-left dot until 640 dots.
// RULE3 - the falling edge of the latch strobe copies the row into the column latches.
// RULE4 - new row data shifts in while the latched row shows; each latch advances the row.
// RULE5 - after the hundredth row the scan wraps to the first row.
// RULE6 - the scan start pulse is loaded into the first scan stage and then moves down.
// RULE7 - the controller makes frames at 70 to 80 Hz.
// RULE8 - drive polarity reverses whenever the polarity toggle changes.
// RULE9 - upper and lower nibbles are shifted by the same shift clock edges.
// RULE10 - column drivers are selected left to right, each for 20 shift clocks.
// RULE11 - driver selection advances together for both halves.
// RULE12 - only the selected driver takes data from the nibble bus.
// RULE13 - the controller resends all rows and timing continuously.
// RULE14 - the controller toggles polarity once per frame and pulses scan start at row one.
// RULE15 - the controller gives 160 shift clocks per row and idles the strobes between rows.
`timescale 1ns/10ps
`default_nettype none
module dual_half_lcd_line_feed
	import lcd_feed_pkg::*;
(
	// clock and reset
	input  wire logic                                mclk_in,
	input  wire logic                                sys_rst_in,
	// controller link
	input  wire logic                                pixel_shift_clock_in,
	input  wire logic                                line_latch_strobe_in,
	input  wire logic                                scan_start_pulse_in,
	input  wire logic                                polarity_toggle_in,
	input  wire logic [lcd_feed_pkg::NIBBLE_W-1:0]   upper_half_nibble_in,
	input  wire logic [lcd_feed_pkg::NIBBLE_W-1:0]   lower_half_nibble_in,
	// panel drive
	output logic      [lcd_feed_pkg::ROW_DOTS-1:0]   upper_column_out,
	output logic      [lcd_feed_pkg::ROW_DOTS-1:0]   lower_column_out,
	output logic      [lcd_feed_pkg::ROWS_PER_HALF-1:0] row_select_out,
	output logic      [lcd_feed_pkg::ROW_IDX_W-1:0]  row_index_out,
	output logic      [lcd_feed_pkg::NUM_DRIVERS-1:0] driver_select_out,
	output logic                                     polarity_out
);
	import lcd_feed_pkg::*;

	// ==========================================
	// two-flop synchronisers
	logic [3:0]          sync1_reg;
	logic [3:0]          sync2_reg;
	logic [NIBBLE_W-1:0] up1_reg;
	logic [NIBBLE_W-1:0] up2_reg;
	logic [NIBBLE_W-1:0] lo1_reg;
	logic [NIBBLE_W-1:0] lo2_reg;
	logic                cp_old_reg;
	logic                lt_old_reg;
	logic                cp_s;
	logic                lt_s;
	logic                ss_s;
	logic                pt_s;
	logic                shift_pulse;
	logic                latch_pulse;

	// data is delayed by the same two flops as the clock, so both arrive aligned
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			up1_reg   <= 4'h0;
			up2_reg   <= 4'h0;
			lo1_reg   <= 4'h0;
			lo2_reg   <= 4'h0;
		end else begin
			sync1_reg <= {polarity_toggle_in, scan_start_pulse_in,
				line_latch_strobe_in, pixel_shift_clock_in};
			sync2_reg <= sync1_reg;
			up1_reg   <= upper_half_nibble_in;
			up2_reg   <= up1_reg;
			lo1_reg   <= lower_half_nibble_in;
			lo2_reg   <= lo1_reg;
		end
	end

	assign cp_s = sync2_reg[0];
	assign lt_s = sync2_reg[1];
	assign ss_s = sync2_reg[2];
	assign pt_s = sync2_reg[3];

	// ==========================================
	// edge detection
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cp_old_reg <= 1'b0;
			lt_old_reg <= 1'b0;
		end else begin
			cp_old_reg <= cp_s;
			lt_old_reg <= lt_s;
		end
	end

	// data is taken on the falling shift clock edge, after setup on the rise
	assign shift_pulse = cp_old_reg & ~cp_s; // RULE9
	assign latch_pulse = lt_old_reg & ~lt_s; // RULE3

	// ==========================================
	// driver select counters, shared by both halves
	logic [DRV_IDX_W-1:0] drv_reg;
	logic [DRV_CNT_W-1:0] pos_reg;
	logic                 row_full_reg;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			drv_reg      <= '0;
			pos_reg      <= '0;
			row_full_reg <= 1'b0;
		end else if (latch_pulse) begin
			drv_reg      <= '0; // RULE10
			pos_reg      <= '0;
			row_full_reg <= 1'b0;
		end else if (shift_pulse && !row_full_reg) begin // RULE2
			if (pos_reg == DRV_CNT_LAST) begin
				pos_reg <= '0;
				if (drv_reg == DRV_IDX_W'(NUM_DRIVERS - 1)) begin
					row_full_reg <= 1'b1;
				end else begin
					drv_reg <= drv_reg + 3'h1; // RULE10 RULE11
				end
			end else begin
				pos_reg <= pos_reg + 5'h01;
			end
		end
	end

	// extra clocks beyond a full row are dropped
	always_comb begin
		driver_select_out = '0;
		if (!row_full_reg) begin
			driver_select_out[drv_reg] = 1'b1;
		end
	end

	// ==========================================
	// column halves
	logic col_shift;
	assign col_shift = shift_pulse & ~row_full_reg;

	lcd_column_half u_upper (
		.mclk_in     (mclk_in),
		.sys_rst_in  (sys_rst_in),
		.shift_in    (col_shift),
		.drv_sel_in  (drv_reg),
		.drv_pos_in  (pos_reg),
		.latch_in    (latch_pulse),
		.polarity_in (polarity_out),
		.nibble_in   (up2_reg),
		.column_out  (upper_column_out)
	);

	lcd_column_half u_lower (
		.mclk_in     (mclk_in),
		.sys_rst_in  (sys_rst_in),
		.shift_in    (col_shift),
		.drv_sel_in  (drv_reg),
		.drv_pos_in  (pos_reg),
		.latch_in    (latch_pulse),
		.polarity_in (polarity_out),
		.nibble_in   (lo2_reg),
		.column_out  (lower_column_out)
	);

	// ==========================================
	// row scan shift chain, same row in both halves
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			row_select_out <= '0;
		end else if (latch_pulse) begin
			row_select_out <= {row_select_out[ROWS_PER_HALF-2:0], ss_s}; // RULE6 RULE4 RULE1
		end
	end

	// row index: scan start restarts it, otherwise it wraps after row 100
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			row_index_out <= '0;
		end else if (latch_pulse) begin
			if (ss_s || row_index_out == ROW_LAST) begin
				row_index_out <= '0; // RULE5
			end else begin
				row_index_out <= row_index_out + 7'h01; // RULE4
			end
		end
	end

	// ==========================================
	// drive polarity follows the toggle level
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			polarity_out <= 1'b0;
		end else begin
			polarity_out <= pt_s; // RULE8
		end
	end
endmodule : dual_half_lcd_line_feed
`default_nettype wire

// ===== lcd_ctrl_model.sv
// partner model: controller sending rows, latch strobe and scan start
`timescale 1ns/10ps
`default_nettype none
module lcd_ctrl_model (
	// bench control
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       send_in,
	input  wire logic       first_in,
	input  wire logic [7:0] nsh_in,
	input  wire logic [3:0] seed_in,
	// link to the panel
	output logic            sclk_out,
	output logic            latch_out,
	output logic            start_out,
	output logic      [3:0] un_out,
	output logic      [3:0] ln_out,
	output logic            done_out
);
	logic [11:0] cnt_reg;
	logic [7:0]  n_reg;
	logic [3:0]  s_reg;
	logic        f_reg;
	logic        busy_reg;
	logic [8:0]  slot;
	logic        shift;
	logic        last;
	assign slot = cnt_reg[11:3];
	assign shift = busy_reg && slot < n_reg;
	assign last = busy_reg && slot == n_reg + 9'h001 && cnt_reg[2:0] == 3'h7;
	assign ln_out = ~un_out;
	// ==========================================
	// row sequencer, eight cycles per link clock
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_reg <= 1'b0;
			cnt_reg <= 12'h000;
			n_reg <= 8'h00;
			f_reg <= 1'b0;
			s_reg <= 4'h0;
		end else if (!busy_reg) begin
			busy_reg <= send_in;
			cnt_reg <= 12'h000;
			n_reg <= nsh_in;
			f_reg <= first_in;
			s_reg <= seed_in;
		end else begin
			busy_reg <= !last;
			// frames run far faster than the flicker-free band; real rate is too slow to simulate
			cnt_reg <= cnt_reg + 12'h001;
		end
	end
	// ==========================================
	// link outputs, registered so they move just after an edge
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{done_out, sclk_out, latch_out, start_out} <= 4'h0;
			un_out <= 4'h0;
		end else begin
			done_out <= last;
			sclk_out <= shift && !cnt_reg[2];
			latch_out <= busy_reg && slot == n_reg && !cnt_reg[2];
			start_out <= busy_reg && f_reg && slot >= n_reg;
			// released lines wander so stale data cannot pass
			un_out <= shift ? slot[3:0] ^ slot[7:4] ^ s_reg : ~un_out;
		end
	end
endmodule : lcd_ctrl_model
`default_nettype wire

// ===== lcd_feed_chk.sv
// checker for the line feed outputs
`timescale 1ns/10ps
`default_nettype none
module lcd_feed_chk
	import lcd_feed_pkg::*;
(
	input wire logic         mclk_in,
	input wire logic         sys_rst_in,
	input wire logic         polarity_toggle_in,
	input wire logic [639:0] upper_column_out,
	input wire logic [639:0] lower_column_out,
	input wire logic [99:0]  row_select_out,
	input wire logic [6:0]   row_index_out,
	input wire logic [7:0]   driver_select_out,
	input wire logic         polarity_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// ==========================================
	// assertions
	chk_drv_onehot: assert property ($onehot0(driver_select_out))
		else $error("driver select not one-hot");
	chk_drv_step: assert property ($changed(driver_select_out) |->
		driver_select_out == 8'h01 || driver_select_out == $past(driver_select_out) << 1)
		else $error("driver select skipped");
	chk_drv_restart: assert property ($changed(row_index_out) |-> driver_select_out == 8'h01)
		else $error("driver select not restarted");
	chk_row_range: assert property (row_index_out <= ROW_LAST)
		else $error("row index out of range");
	chk_row_step: assert property ($changed(row_index_out) |->
		row_index_out == 7'h00 || row_index_out == $past(row_index_out) + 7'h01)
		else $error("row index jumped");
	chk_row_first: assert property (row_select_out[0] |-> row_index_out == 7'h00)
		else $error("first row away from index zero");
	chk_pol_follow: assert property ($stable(polarity_toggle_in)[*6] |->
		polarity_out == polarity_toggle_in)
		else $error("polarity not followed");
	chk_col_invert: assert property ($changed(polarity_out) |=>
		upper_column_out == ~$past(upper_column_out) && lower_column_out == ~$past(lower_column_out))
		else $error("columns not inverted");
	cover property (row_index_out == ROW_LAST);
	cover property ($changed(polarity_out));
	cover property (driver_select_out[7]);
endmodule : lcd_feed_chk
bind dual_half_lcd_line_feed lcd_feed_chk i_chk (.mclk_in, .sys_rst_in, .polarity_toggle_in,
	.upper_column_out, .lower_column_out, .row_select_out, .row_index_out,
	.driver_select_out, .polarity_out);
`default_nettype wire

// ===== dual_half_lcd_line_feed_tb.sv
// bench for the line feed: rows, polarity, refusal, wrap
`timescale 1ns/10ps
`default_nettype none
module dual_half_lcd_line_feed_tb;
	import lcd_feed_pkg::*;
	typedef struct packed {
		logic [639:0] u;
		logic [639:0] l;
		logic [99:0] s;
		logic [6:0] i;
	} exp_t;
	logic mclk_in, sys_rst_in, pol, send, first, sclk, latch, start, done, pout;
	logic [7:0] nsh, dsel;
	logic [3:0] seed, un, ln;
	logic [639:0] ucol, lcol, eu, el;
	logic [99:0] rsel, esel;
	logic [6:0] ridx, eidx;
	exp_t q[$];
	exp_t e;
	int errors, cmp_count;
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	lcd_ctrl_model i_ctrl (.mclk_in, .sys_rst_in, .send_in(send), .first_in(first),
		.nsh_in(nsh), .seed_in(seed), .sclk_out(sclk), .latch_out(latch),
		.start_out(start), .un_out(un), .ln_out(ln), .done_out(done));
	dual_half_lcd_line_feed i_dut (.mclk_in, .sys_rst_in, .pixel_shift_clock_in(sclk),
		.line_latch_strobe_in(latch), .scan_start_pulse_in(start), .polarity_toggle_in(pol),
		.upper_half_nibble_in(un), .lower_half_nibble_in(ln), .upper_column_out(ucol),
		.lower_column_out(lcol), .row_select_out(rsel), .row_index_out(ridx),
		.driver_select_out(dsel), .polarity_out(pout));
	// ==========================================
	// checking and verdict
	task automatic check(string nm, logic [639:0] s, logic [639:0] x);
		cmp_count++;
		if (s !== x) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	// one row: n shifts then a latch; only the first 160 count
	task automatic row(input int n, input logic f);
		logic [3:0] s;
		logic [3:0] v;
		s = 4'($urandom);
		@(posedge mclk_in);
		send <= 1'b1;
		nsh <= 8'(n);
		first <= f;
		seed <= s;
		@(posedge mclk_in);
		send <= 1'b0;
		for (int j = 0; j < n && j < 160; j++) begin
			v = 4'(j) ^ 4'(j >> 4) ^ s;
			for (int b = 0; b < 4; b++) begin
				eu[4*j+b] = v[3-b];
				el[4*j+b] = ~v[3-b];
			end
		end
		eidx = f ? 7'h00 : (eidx == ROW_LAST ? 7'h00 : eidx + 7'h01);
		esel = {esel[98:0], f};
		q.push_back('{eu ^ {640{pol}}, el ^ {640{pol}}, esel, eidx});
		for (int w = 0; w < 4000 && done !== 1'b1; w++) @(posedge mclk_in);
		if (done !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask : row
	// ==========================================
	// watcher: oldest note against the latched outputs
	always @(posedge mclk_in) begin
		if (done === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			check("upper_col", ucol, e.u);
			check("lower_col", lcol, e.l);
			check("row_sel", 640'(rsel), 640'(e.s));
			check("row_idx", 640'(ridx), 640'(e.i));
			check("drv_sel", 640'(dsel), 640'h1);
			check("polarity", 640'(pout), 640'(pol));
		end
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h505EDC63));
		{sys_rst_in, pol, send, first, nsh, seed} = {1'b1, 3'h0, 8'h00, 4'h0};
		{eu, el, esel, eidx, errors, cmp_count} = '0;
		repeat (12) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		row(160, 1'b1);
		$display("test full_row done");
		pol <= 1'b1;
		row(160, 1'b0);
		$display("test polarity done");
		row(200, 1'b0);
		$display("test extra_shifts done");
		row(25, 1'b0);
		$display("test short_row done");
		// latch-only rows reach the last row, wrap, then restart mid-frame
		for (int i = 0; i < 99; i++) row(0, i == 98);
		$display("test wrap_restart done");
		print_verdict();
	end
endmodule : dual_half_lcd_line_feed_tb
`default_nettype wire
